// *** hdl/swg_guard.sv ***
// Purpose: supervisory state machine for an input supply protector
// Assumes: trip inputs come from comparators, synchronous to clock
// Notes:   srst stands for the power-up condition
`timescale 1ns/1ps
module swg_guard #(
   parameter int unsigned DEB_LIMIT = swg_pkg::DEB_CYCLES
) (
   input  wire logic                  clock,
   input  wire logic                  srst,
   input  wire swg_pkg::swg_trip_type trip,
   output swg_pkg::swg_drive_type     drive,
   output swg_pkg::swg_state_type     state
);
   import swg_pkg::*;

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   swg_state_type state_reg;
   swg_state_type state_next;
   logic          in_window;
   logic          timer_run;
   logic          timer_done;
   logic          switch_off_reg;
   logic          fault_oe_n_reg;

   // strictly inside: neither comparator tripped
   assign in_window = !trip.low_trip_lockout && !trip.high_trip_lockout;
   assign timer_run = (state_reg == ST_DEBOUNCE) && in_window;

   // -----------------------------------------------------------------
   // debounce timer
   // -----------------------------------------------------------------
   swg_timer #(
      .LIMIT (DEB_LIMIT)
   ) u_timer (
      .clock (clock),
      .srst  (srst),
      .run   (timer_run),
      .done  (timer_done)
   );

   // -----------------------------------------------------------------
   // state machine
   // -----------------------------------------------------------------
   // next state; excursions win over everything
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_LOCKOUT: begin
            if (in_window) begin
               state_next = ST_DEBOUNCE;
            end
         end
         ST_DEBOUNCE: begin
            if (!in_window) begin
               state_next = ST_LOCKOUT;
            end else if (timer_done) begin
               state_next = ST_ON;
            end
         end
         ST_ON: begin
            if (!in_window) begin
               state_next = ST_LOCKOUT;
            end
         end
         default: begin
            state_next = ST_LOCKOUT;
         end
      endcase
   end

   // state register; power-up lands in lockout
   always_ff @(posedge clock) begin
      if (srst) begin
         state_reg <= ST_LOCKOUT;
      end else begin
         state_reg <= state_next;
      end
   end

   // -----------------------------------------------------------------
   // output drives
   // -----------------------------------------------------------------
   // registered from state_next so an excursion shows one edge later,
   // the fastest a registered output can react
   always_ff @(posedge clock) begin
      if (srst) begin
         switch_off_reg <= 1'b1;
      end else begin
         switch_off_reg <= (state_next != ST_ON);
      end
   end

   // open-drain fault: enable low pulls the line low while normal
   always_ff @(posedge clock) begin
      if (srst) begin
         fault_oe_n_reg <= 1'b1;
      end else begin
         fault_oe_n_reg <= (state_next != ST_ON);
      end
   end

   assign drive.switch_off = switch_off_reg;
   assign drive.fault_out  = 1'b0;
   assign drive.fault_oe_n = fault_oe_n_reg;
   assign state            = state_reg;

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   logic [CNT_W-1:0] win_cnt_reg;

   // helper: cycles since the window was entered
   always_ff @(posedge clock) begin
      if (srst || !in_window) begin
         win_cnt_reg <= CNT_RESET;
      end else if (win_cnt_reg != {CNT_W{1'b1}}) begin
         win_cnt_reg <= win_cnt_reg + 1'b1;
      end
   end

   a_reset_outputs_high: assert property (
      @(posedge clock) srst |=> (drive.switch_off && drive.fault_oe_n))
      else $error("outputs not high after power-up");

   a_excursion_kills: assert property (
      @(posedge clock) disable iff (srst) !in_window |=> drive.switch_off && drive.fault_oe_n)
      else $error("excursion did not force both outputs high");

   a_fault_holds_off: assert property (
      @(posedge clock) disable iff (srst)
      (!in_window)[*2] |-> drive.switch_off)
      else $error("switch drive dropped during a fault");

   a_on_drives_low: assert property (
      @(posedge clock) disable iff (srst)
      (state_reg == ST_ON) && in_window |=> !drive.switch_off)
      else $error("switch drive high in on state");

   a_deb_not_early: assert property (
      @(posedge clock) disable iff (srst)
      $fell(drive.switch_off) |-> ($past(win_cnt_reg) >= CNT_W'(DEB_LIMIT)))
      else $error("switch turned on before debounce interval");

   a_deb_not_late: assert property (
      @(posedge clock) disable iff (srst)
      (win_cnt_reg == CNT_W'(DEB_LIMIT + 2)) |-> !drive.switch_off)
      else $error("switch not on after debounce interval");

   a_restart_timer: assert property (
      @(posedge clock) disable iff (srst)
      (state_reg == ST_DEBOUNCE) && !in_window |=> (state_reg == ST_LOCKOUT))
      else $error("debounce not abandoned on excursion");

   a_fault_tracks: assert property (
      @(posedge clock) disable iff (srst)
      drive.fault_oe_n == drive.switch_off)
      else $error("fault indication disagrees with switch drive");

   a_open_drain: assert property (
      @(posedge clock) disable iff (srst) drive.fault_out == 1'b0)
      else $error("fault output would drive high");

   // flag must sink the line whenever the on state holds in window
   a_flag_normal: assert property (
      @(posedge clock) disable iff (srst)
      (state_reg == ST_ON) && in_window |=> !drive.fault_oe_n)
      else $error("fault line released in normal operation");

   // no path may skip the debounce wait
   a_lockout_no_on: assert property (
      @(posedge clock) disable iff (srst)
      (state_reg == ST_LOCKOUT) |=> (state_reg != ST_ON))
      else $error("lockout jumped straight to on");

   // on state only follows an in-window cycle
   a_on_needs_window: assert property (
      @(posedge clock) disable iff (srst)
      (state_reg == ST_ON) |-> $past(in_window))
      else $error("on state held across an excursion");

   // the gate only turns off on an excursion or a power-up
   a_no_spurious_off: assert property (
      @(posedge clock) disable iff (srst)
      $rose(drive.switch_off) |-> $past(!in_window || srst))
      else $error("switch drive rose with supply in window");

   // encoding 2'b11 is never reached, so no state escapes the excursion check
   a_state_legal: assert property (
      @(posedge clock) disable iff (srst)
      state_reg inside {ST_LOCKOUT, ST_DEBOUNCE, ST_ON})
      else $error("state register left the legal codes");

   // power-up leaves the machine in lockout
   a_srst_lockout: assert property (
      @(posedge clock) srst |=> (state_reg == ST_LOCKOUT))
      else $error("state not lockout after power-up");

   // -----------------------------------------------------------------
   // cover properties
   // -----------------------------------------------------------------
   // first turn-on, aborted count, trip from on, reset from on, both trips
   c_power_on: cover property (
      @(posedge clock) disable iff (srst) $fell(drive.switch_off));
   c_deb_abort: cover property (
      @(posedge clock) disable iff (srst)
      (state_reg == ST_DEBOUNCE) ##1 (state_reg == ST_LOCKOUT));
   c_on_trip: cover property (
      @(posedge clock) disable iff (srst)
      (state_reg == ST_ON) ##1 (state_reg == ST_LOCKOUT));
   c_reset_from_on: cover property (
      @(posedge clock) (state_reg == ST_ON) && srst);
   c_both_trips: cover property (
      @(posedge clock) disable iff (srst)
      trip.low_trip_lockout && trip.high_trip_lockout);

endmodule

// *** hdl/swg_pkg.sv ***
// Purpose: shared constants and types for the supply window guard
// Assumes: 200 MHz clock
// Notes:   debounce interval is 20 ms nominal, 10 ms to 34 ms allowed
package swg_pkg;

   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int unsigned CLK_FREQ_HZ      = 200_000_000;
   localparam int unsigned DEB_TIME_MS      = 20;
   localparam int unsigned DEB_MIN_MS       = 10;
   localparam int unsigned DEB_MAX_MS       = 34;
   localparam int unsigned DEB_CYCLES       = (CLK_FREQ_HZ / 1000) * DEB_TIME_MS;
   localparam int unsigned DEB_MIN_CYCLES   = (CLK_FREQ_HZ / 1000) * DEB_MIN_MS;
   localparam int unsigned DEB_MAX_CYCLES   = (CLK_FREQ_HZ / 1000) * DEB_MAX_MS;
   localparam int unsigned CNT_W            = 24;
   localparam logic [CNT_W-1:0] CNT_RESET   = 24'h000000;

   // -----------------------------------------------------------------
   // state and carriers
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_LOCKOUT = 2'b00,
      ST_DEBOUNCE = 2'b01,
      ST_ON      = 2'b10
   } swg_state_type;

   typedef struct packed {
      logic low_trip_lockout;
      logic high_trip_lockout;
   } swg_trip_type;

   typedef struct packed {
      logic switch_off;
      logic fault_out;
      logic fault_oe_n;
   } swg_drive_type;

endpackage

// *** hdl/swg_timer.sv ***
// Purpose: debounce timer for the supply window guard
// Assumes: run is held high while counting; a low run clears the count
// Notes:   done is a level that stays high while run holds once the limit is reached
`timescale 1ns/1ps
module swg_timer #(
   parameter int unsigned LIMIT = swg_pkg::DEB_CYCLES
) (
   input  wire logic clock,
   input  wire logic srst,
   input  wire logic run,
   output logic      done
);
   import swg_pkg::*;

   localparam logic [CNT_W-1:0] LAST = CNT_W'(LIMIT - 1);

   logic [CNT_W-1:0] count_reg;

   // -----------------------------------------------------------------
   // counter
   // -----------------------------------------------------------------
   // a dropped run throws the partial count away
   always_ff @(posedge clock) begin
      if (srst || !run) begin
         count_reg <= CNT_RESET;
      end else if (count_reg != LAST) begin
         count_reg <= count_reg + 1'b1;
      end
   end

   assign done = run && (count_reg == LAST);

endmodule

// *** bench/swg_host_model.sv ***
// Purpose: far side of the guard: pass transistor and host fault input
// Assumes: fault line has a host pull-up, no other driver
// Notes:   pass_on is the transistor conducting state
`timescale 1ns/1ps
module swg_host_model (
   input  wire swg_pkg::swg_drive_type drive,
   output logic                        fault_line,
   output logic                        pass_on
);
   import swg_pkg::*;
   // pull-up wins unless the guard sinks the line; high reads as fault
   assign fault_line = drive.fault_oe_n ? 1'b1 : drive.fault_out;
   // gate high keeps the transistor off
   assign pass_on    = ~drive.switch_off;
endmodule

// *** bench/test_swg_guard.sv ***
// Purpose: self-checking bench for the supply window guard
// Assumes: short debounce limit so the run stays brief
// Notes:   trips change at a rising edge, outputs checked 1 ns later
`timescale 1ns/1ps
module test_swg_guard;
   import swg_pkg::*;
   // -----------------------------------------------------------------
   // signals and instances
   // -----------------------------------------------------------------
   localparam int unsigned LIM = 16;
   logic          clock;
   logic          srst;
   swg_trip_type  trip;
   swg_drive_type drive;
   swg_state_type state;
   logic          fault_line;
   logic          pass_on;
   int            fails;
   int            check_count;
   swg_guard #(.DEB_LIMIT(LIM)) u_swg_guard (.clock(clock), .srst(srst), .trip(trip),
      .drive(drive), .state(state));
   swg_host_model u_swg_host_model (.drive(drive), .fault_line(fault_line),
      .pass_on(pass_on));
   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: %s got %0h expected %0h", $time, what, seen, exp);
      end
   endtask
   // edges from the in-window edge until the gate drive drops, bounded
   task automatic measure(output int n);
      n = 0;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (drive.switch_off !== 1'b0 && n < 100);
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic t_power_up;
      repeat (4) @(posedge clock);
      #1;
      check(drive.switch_off, 1'b1, "gate at power-up");
      check(fault_line, 1'b1, "flag at power-up");
      check(drive.fault_out, 1'b0, "sink level");
      check(state, ST_LOCKOUT, "state at power-up");
   endtask
   task automatic t_debounce;
      int n;
      @(posedge clock);
      trip <= '0;
      measure(n);
      check(n, LIM + 1, "debounce length");
      check(pass_on, 1'b1, "transistor on");
      check(fault_line, 1'b0, "flag normal");
      check(state, ST_ON, "state on");
   endtask
   // one-edge reaction to an excursion, held while it lasts
   task automatic t_excursion(input logic lo, input logic hi);
      @(posedge clock);
      trip.low_trip_lockout  <= lo;
      trip.high_trip_lockout <= hi;
      @(posedge clock);
      #1;
      check(drive.switch_off, 1'b1, "gate on excursion");
      check(fault_line, 1'b1, "flag on excursion");
      repeat (5) @(posedge clock);
      #1;
      check(drive.switch_off, 1'b1, "gate during fault");
      check(state, ST_LOCKOUT, "state during fault");
   endtask
   // dropout mid-count must restart the full interval
   task automatic t_abort;
      int n;
      @(posedge clock);
      trip <= '0;
      repeat (10) @(posedge clock);
      trip.high_trip_lockout <= 1'b1;
      @(posedge clock);
      trip.high_trip_lockout <= 1'b0;
      measure(n);
      check(n, LIM + 1, "restart after dropout");
   endtask
   // power-up again from the on state, then a full debounce
   task automatic t_mid_reset;
      int n;
      @(posedge clock);
      srst <= 1'b1;
      @(posedge clock);
      #1;
      check(drive.switch_off, 1'b1, "gate in reset");
      check(fault_line, 1'b1, "flag in reset");
      check(state, ST_LOCKOUT, "state in reset");
      @(posedge clock);
      srst <= 1'b0;
      measure(n);
      check(n, LIM + 1, "debounce after reset");
   endtask
   // -----------------------------------------------------------------
   // main sequence and watchdog
   // -----------------------------------------------------------------
   initial begin
      fails = 0;
      check_count = 0;
      srst = 1'b1;
      trip = '{low_trip_lockout: 1'b1, high_trip_lockout: 1'b0};
      repeat (3) @(posedge clock);
      srst <= 1'b0;
      t_power_up();
      t_debounce();
      t_excursion(1'b0, 1'b1);
      t_debounce();
      t_excursion(1'b1, 1'b0);
      t_abort();
      t_mid_reset();
      t_excursion(1'b1, 1'b1);
      end_of_test();
   end
   // far beyond the roughly 113 cycles the scenarios need
   initial begin
      #100000;
      fails++;
      end_of_test();
   end
endmodule
